// ### pkg/odrm_pkg.sv
// constants for the output driver register map
package odrm_pkg;
  // operation codes of the command byte
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_READ_CLEAR = 2'h2;
  localparam logic [1:0] OP_READ_INFO = 2'h3;
  // working register space
  localparam logic [5:0] ADDR_BRIDGE_SWITCH = 6'h00;
  localparam logic [5:0] ADDR_HIGHSIDE_SWITCH = 6'h01;
  localparam logic [5:0] ADDR_BRIDGE_RECOVERY = 6'h02;
  localparam logic [5:0] ADDR_HIGHSIDE_RECOVERY = 6'h03;
  localparam logic [5:0] ADDR_OVERCURRENT = 6'h10;
  localparam logic [5:0] ADDR_OPENLOAD = 6'h11;
  localparam logic [5:0] ADDR_OPENLOAD_SUPPLY = 6'h12;
  localparam logic [5:0] ADDR_MASK_CONFIG = 6'h3f;
  // information space
  localparam logic [5:0] ADDR_INFO_HEADER = 6'h00;
  localparam logic [5:0] ADDR_INFO_REVISION = 6'h01;
  localparam logic [5:0] ADDR_INFO_PART_A = 6'h02;
  localparam logic [5:0] ADDR_INFO_PART_B = 6'h03;
  localparam logic [5:0] ADDR_FRAME_FORMAT = 6'h3e;
  localparam logic [15:0] FRAME_FORMAT_VALUE = 16'h0200;
  // reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [7:0] GLOBAL_RESET = 8'h20;
  // writable bits; reserved bits are stored as zero
  localparam logic [15:0] BRIDGE_SWITCH_BITS = 16'hfff1;
  localparam logic [15:0] HIGHSIDE_SWITCH_BITS = 16'hfe00;
  // field positions
  localparam int ENABLE_BIT = 0;
  localparam int BRIDGE_LSB = 4;
  localparam int NUM_BRIDGES = 6;
  localparam int CFG_A_FIRST = 15;
  localparam int CFG_A_SECOND = 14;
  localparam int CFG_B_FIRST = 13;
  localparam int CFG_B_SECOND = 12;
  localparam int HS_EXTRA_LSB = 9;
  localparam int NUM_DRIVERS = 19;
  // global status byte positions
  localparam int GS_GLOBAL = 7;
  localparam int GS_COMM = 6;
  localparam int GS_CHIP_RESET = 5;
  localparam int GS_THERMAL_SD = 4;
  localparam int GS_THERMAL_WARN = 3;
  localparam int GS_SUPPLY_OC = 2;
  localparam int GS_OPEN_LOAD = 1;
  localparam int GS_NOT_READY = 0;
  // mask configuration bits
  localparam int MASK_THERMAL_WARN = 3;
  localparam int MASK_OPEN_LOAD = 1;
endpackage

// ### verilog/odrm_driver_gate.sv
// one output driver: request gated by the optional pulse input, registered
`timescale 1ns/1ps
module odrm_driver_gate
  import odrm_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // request and pulse gating
  input wire logic req_in,
  input wire logic pwm_en_in,
  input wire logic pwm_in,
  // driver
  output logic on_out
);
  wire next_on = req_in & (~pwm_en_in | pwm_in);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      on_out <= 1'b0;
    else
      on_out <= next_on;
  end
endmodule

// ### verilog/odrm_register_map.sv
// register map and output switch control of the multi-output driver
//
// Function
// RQ1: read/write control registers at 00h to 03h
// RQ2: read-only diagnostic status at 10h, 11h, 12h
// RQ3: mask register 3Fh gates global status bits
// RQ4: information space 3Eh returns frame format 0200h
// RQ5: register 0 bits 15..4 switch bridge drivers
// RQ6: pulse enable gates driver by pulse input
// RQ7: never both drivers of one bridge on
// RQ8: enable bit set selects active mode
// RQ9: enable bit clear: standby, register cleared
// RQ10: host writes zero to reserved bits
// RQ11: register 1 bits 15..12 are mode fields
// RQ12: mode 10 low, 01 high, else off
// RQ13: register 1 bits 11..9 switch extra drivers
// RQ14: write answers previous register content
// RQ15: both bridge bits set keeps bridge off
// RQ16: unlisted address reads zero, changes nothing
`timescale 1ns/1ps
module odrm_register_map
  import odrm_pkg::*;
#(
  // identification words; values are arbitrary
  parameter logic [15:0] INFO_HEADER = 16'h1234,
  parameter logic [15:0] INFO_REVISION = 16'h0001,
  parameter logic [15:0] INFO_PART_A = 16'h5a5a,
  parameter logic [15:0] INFO_PART_B = 16'ha5a5
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // decoded command frame
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_op_in,
  input wire logic [5:0] cmd_addr_in,
  input wire logic [15:0] cmd_wdata_in,
  // in-frame answer
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out,
  output logic [7:0] global_status_out,
  // diagnostic events and flags
  input wire logic [15:0] overcurrent_event_in,
  input wire logic [15:0] openload_event_in,
  input wire logic [15:0] supply_event_in,
  input wire logic comm_error_in,
  input wire logic chip_reset_in,
  input wire logic thermal_shutdown_in,
  input wire logic thermal_warning_in,
  input wire logic not_ready_in,
  // pulse gate inputs
  input wire logic pulse_gate_input_a_in,
  input wire logic pulse_gate_input_b_in,
  // drivers
  output logic active_out,
  output logic [5:0] half_bridge_hs_out,
  output logic [5:0] half_bridge_ls_out,
  output logic config_highside_output_a_low_out,
  output logic config_highside_output_a_high_out,
  output logic config_highside_output_b_low_out,
  output logic config_highside_output_b_high_out,
  output logic highside_output_c_out,
  output logic highside_output_d_out,
  output logic highside_output_e_out
);
  logic rst_sync1;
  logic rst_n;
  logic [15:0] bridge_switch_control;
  logic [15:0] highside_switch_control;
  logic [15:0] bridge_recovery_pwm_setup;
  logic [15:0] highside_recovery_pwm_setup;
  logic [15:0] bridge_overcurrent_status;
  logic [15:0] bridge_openload_status;
  logic [15:0] openload_supply_status;
  logic [15:0] status_mask_config;
  logic [NUM_DRIVERS-1:0] drv_on;

  // reset release through two flip-flops
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_sync1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_sync1 <= 1'b1;
      rst_n <= rst_sync1;
    end
  end

  // command decode
  wire is_info = cmd_op_in == OP_READ_INFO;
  wire is_write = cmd_valid_in && cmd_op_in == OP_WRITE;
  wire is_clear = cmd_valid_in && cmd_op_in == OP_READ_CLEAR;
  wire wr_bridge = is_write && cmd_addr_in == ADDR_BRIDGE_SWITCH; // [RQ1]
  wire wr_highside = is_write && cmd_addr_in == ADDR_HIGHSIDE_SWITCH;
  wire wr_brec = is_write && cmd_addr_in == ADDR_BRIDGE_RECOVERY;
  wire wr_hrec = is_write && cmd_addr_in == ADDR_HIGHSIDE_RECOVERY;
  wire wr_mask = is_write && cmd_addr_in == ADDR_MASK_CONFIG; // [RQ3]
  wire clr_oc = is_clear && cmd_addr_in == ADDR_OVERCURRENT;
  wire clr_ol = is_clear && cmd_addr_in == ADDR_OPENLOAD;
  wire clr_sup = is_clear && cmd_addr_in == ADDR_OPENLOAD_SUPPLY;

  // read data of the working space; unlisted addresses give zero
  wire [15:0] ram_data =
    (cmd_addr_in == ADDR_BRIDGE_SWITCH) ? bridge_switch_control :
    (cmd_addr_in == ADDR_HIGHSIDE_SWITCH) ? highside_switch_control :
    (cmd_addr_in == ADDR_BRIDGE_RECOVERY) ? bridge_recovery_pwm_setup :
    (cmd_addr_in == ADDR_HIGHSIDE_RECOVERY) ? highside_recovery_pwm_setup :
    (cmd_addr_in == ADDR_OVERCURRENT) ? bridge_overcurrent_status : // [RQ2]
    (cmd_addr_in == ADDR_OPENLOAD) ? bridge_openload_status :
    (cmd_addr_in == ADDR_OPENLOAD_SUPPLY) ? openload_supply_status :
    (cmd_addr_in == ADDR_MASK_CONFIG) ? status_mask_config : 16'h0000; // [RQ16]
  wire [15:0] info_data =
    (cmd_addr_in == ADDR_INFO_HEADER) ? INFO_HEADER :
    (cmd_addr_in == ADDR_INFO_REVISION) ? INFO_REVISION :
    (cmd_addr_in == ADDR_INFO_PART_A) ? INFO_PART_A :
    (cmd_addr_in == ADDR_INFO_PART_B) ? INFO_PART_B :
    (cmd_addr_in == ADDR_FRAME_FORMAT) ? FRAME_FORMAT_VALUE : 16'h0000; // [RQ4] [RQ16]
  // a write answers what the register held before it
  wire [15:0] next_rsp_data = is_info ? info_data : ram_data; // [RQ14]

  // clearing the enable bit drops the whole register
  wire [15:0] next_bridge = cmd_wdata_in[ENABLE_BIT] ?
    (cmd_wdata_in & BRIDGE_SWITCH_BITS) : CTRL_RESET; // [RQ8] [RQ9] [RQ10]
  wire [15:0] next_highside = cmd_wdata_in & HIGHSIDE_SWITCH_BITS; // [RQ10]
  // events win over a read-and-clear in the same cycle
  wire [15:0] next_oc = (clr_oc ? STATUS_RESET : bridge_overcurrent_status) |
    overcurrent_event_in;
  wire [15:0] next_ol = (clr_ol ? STATUS_RESET : bridge_openload_status) |
    openload_event_in;
  wire [15:0] next_sup = (clr_sup ? STATUS_RESET : openload_supply_status) |
    supply_event_in;

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bridge_switch_control <= CTRL_RESET;
      highside_switch_control <= CTRL_RESET;
      bridge_recovery_pwm_setup <= CTRL_RESET;
      highside_recovery_pwm_setup <= CTRL_RESET;
      status_mask_config <= CTRL_RESET;
    end
    else
    begin
      if (wr_bridge)
        bridge_switch_control <= next_bridge;
      if (wr_highside)
        highside_switch_control <= next_highside;
      if (wr_brec)
        bridge_recovery_pwm_setup <= cmd_wdata_in;
      if (wr_hrec)
        highside_recovery_pwm_setup <= cmd_wdata_in;
      if (wr_mask)
        status_mask_config <= cmd_wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bridge_overcurrent_status <= STATUS_RESET;
      bridge_openload_status <= STATUS_RESET;
      openload_supply_status <= STATUS_RESET;
    end
    else
    begin
      bridge_overcurrent_status <= next_oc; // [RQ2]
      bridge_openload_status <= next_ol;
      openload_supply_status <= next_sup;
    end
  end

  // global status byte with masking
  wire tw_shown = thermal_warning_in & ~status_mask_config[MASK_THERMAL_WARN]; // [RQ3]
  wire ol_shown = (|bridge_openload_status | |openload_supply_status) &
    ~status_mask_config[MASK_OPEN_LOAD]; // [RQ3]
  wire uov_oc = |bridge_overcurrent_status | |openload_supply_status;
  wire gl_err = comm_error_in | ~chip_reset_in | thermal_shutdown_in | tw_shown |
    uov_oc | ol_shown | not_ready_in;
  wire [7:0] next_global = {gl_err, comm_error_in, chip_reset_in, thermal_shutdown_in,
    tw_shown, uov_oc, ol_shown, not_ready_in};

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 16'h0000;
      global_status_out <= GLOBAL_RESET;
    end
    else
    begin
      rsp_valid_out <= cmd_valid_in;
      rsp_data_out <= next_rsp_data;
      global_status_out <= next_global;
    end
  end

  // driver requests
  wire [5:0] bridge_hs_bits;
  wire [5:0] bridge_ls_bits;
  genvar g;
  generate
    for (g = 0; g < NUM_BRIDGES; g++)
    begin : g_pair
      assign bridge_hs_bits[g] = bridge_switch_control[BRIDGE_LSB + 2*g + 1]; // [RQ5]
      assign bridge_ls_bits[g] = bridge_switch_control[BRIDGE_LSB + 2*g];
    end
  endgenerate
  // a bridge with both bits set stays fully off
  wire [5:0] bridge_conflict = bridge_hs_bits & bridge_ls_bits; // [RQ7] [RQ15]
  wire [5:0] hs_req = bridge_hs_bits & ~bridge_conflict;
  wire [5:0] ls_req = bridge_ls_bits & ~bridge_conflict;
  wire [1:0] mode_a = {highside_switch_control[CFG_A_FIRST],
    highside_switch_control[CFG_A_SECOND]}; // [RQ11]
  wire [1:0] mode_b = {highside_switch_control[CFG_B_FIRST],
    highside_switch_control[CFG_B_SECOND]};
  wire [3:0] cfg_req = {mode_b == 2'h1, mode_b == 2'h2,
    mode_a == 2'h1, mode_a == 2'h2}; // [RQ12]
  wire [2:0] extra_req = highside_switch_control[HS_EXTRA_LSB +: 3]; // [RQ13]
  wire [NUM_DRIVERS-1:0] req = {extra_req, cfg_req, ls_req, hs_req};
  wire [NUM_DRIVERS-1:0] pwm_en = {
    highside_recovery_pwm_setup[HS_EXTRA_LSB +: 3],
    {2{highside_recovery_pwm_setup[CFG_B_SECOND]}},
    {2{highside_recovery_pwm_setup[CFG_A_SECOND]}},
    {bridge_recovery_pwm_setup[14], bridge_recovery_pwm_setup[12],
      bridge_recovery_pwm_setup[10], bridge_recovery_pwm_setup[8],
      bridge_recovery_pwm_setup[6], bridge_recovery_pwm_setup[4]},
    {bridge_recovery_pwm_setup[15], bridge_recovery_pwm_setup[13],
      bridge_recovery_pwm_setup[11], bridge_recovery_pwm_setup[9],
      bridge_recovery_pwm_setup[7], bridge_recovery_pwm_setup[5]}};
  wire [NUM_DRIVERS-1:0] pwm_src = {{7{pulse_gate_input_b_in}}, {12{pulse_gate_input_a_in}}};

  generate
    for (g = 0; g < NUM_DRIVERS; g++)
    begin : g_drv
      odrm_driver_gate u_gate (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .req_in(req[g]),
        .pwm_en_in(pwm_en[g]),
        .pwm_in(pwm_src[g]), // [RQ6]
        .on_out(drv_on[g])
      );
    end
  endgenerate

  assign active_out = bridge_switch_control[ENABLE_BIT]; // [RQ8]
  assign half_bridge_hs_out = drv_on[5:0];
  assign half_bridge_ls_out = drv_on[11:6];
  assign config_highside_output_a_low_out = drv_on[12];
  assign config_highside_output_a_high_out = drv_on[13];
  assign config_highside_output_b_low_out = drv_on[14];
  assign config_highside_output_b_high_out = drv_on[15];
  assign highside_output_c_out = drv_on[18]; // [RQ13]
  assign highside_output_d_out = drv_on[17];
  assign highside_output_e_out = drv_on[16];

  // checks
  sequence s_write_bridge;
    cmd_valid_in && cmd_op_in == OP_WRITE && cmd_addr_in == ADDR_BRIDGE_SWITCH;
  endsequence

  property p_no_shoot;
    @(posedge clk_in) disable iff (!rst_n)
    (half_bridge_hs_out & half_bridge_ls_out) == 6'h00;
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("bridge shoot-through"); // [RQ7]

  property p_write_prev;
    @(posedge clk_in) disable iff (!rst_n)
    s_write_bridge |=> rsp_valid_out && rsp_data_out == $past(bridge_switch_control);
  endproperty
  a_write_prev: assert property (p_write_prev) else $error("write answer wrong"); // [RQ14]

  property p_standby;
    @(posedge clk_in) disable iff (!rst_n)
    s_write_bridge ##0 !cmd_wdata_in[ENABLE_BIT] |=> bridge_switch_control == CTRL_RESET
      && !active_out ##1 half_bridge_hs_out == 6'h00;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered"); // [RQ9]

  property p_active;
    @(posedge clk_in) disable iff (!rst_n)
    s_write_bridge ##0 cmd_wdata_in[ENABLE_BIT] |=> active_out;
  endproperty
  a_active: assert property (p_active) else $error("active not entered"); // [RQ8]

  property p_frame_id;
    @(posedge clk_in) disable iff (!rst_n)
    cmd_valid_in && is_info && cmd_addr_in == ADDR_FRAME_FORMAT
      |=> rsp_data_out == 16'h0200;
  endproperty
  a_frame_id: assert property (p_frame_id) else $error("frame format wrong"); // [RQ4]

  property p_unlisted;
    @(posedge clk_in) disable iff (!rst_n)
    cmd_valid_in && !is_info && cmd_addr_in inside {[6'h04:6'h0f], [6'h13:6'h3e]}
      |=> rsp_data_out == 16'h0000 && $stable(bridge_switch_control);
  endproperty
  a_unlisted: assert property (p_unlisted) else $error("unlisted address"); // [RQ16]

  property p_both_off;
    @(posedge clk_in) disable iff (!rst_n)
    bridge_switch_control[15] && bridge_switch_control[14]
      |=> !half_bridge_hs_out[5] && !half_bridge_ls_out[5];
  endproperty
  a_both_off: assert property (p_both_off) else $error("conflicting bridge on"); // [RQ15]

  property p_pwm_gate;
    @(posedge clk_in) disable iff (!rst_n)
    bridge_recovery_pwm_setup[15] && !pulse_gate_input_a_in |=> !half_bridge_hs_out[5];
  endproperty
  a_pwm_gate: assert property (p_pwm_gate) else $error("pulse gate ignored"); // [RQ6]

  property p_mode_off;
    @(posedge clk_in) disable iff (!rst_n)
    mode_a == 2'h3 || mode_a == 2'h0
      |=> !config_highside_output_a_low_out && !config_highside_output_a_high_out;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("mode off violated"); // [RQ12]

  property p_mode_low;
    @(posedge clk_in) disable iff (!rst_n)
    mode_b == 2'h2 && !highside_recovery_pwm_setup[CFG_B_SECOND]
      |=> config_highside_output_b_low_out && !config_highside_output_b_high_out;
  endproperty
  a_mode_low: assert property (p_mode_low) else $error("low mode wrong"); // [RQ11]

  property p_status_read;
    @(posedge clk_in) disable iff (!rst_n)
    cmd_valid_in && cmd_op_in == OP_READ && cmd_addr_in == ADDR_OVERCURRENT
      |=> rsp_data_out == $past(bridge_overcurrent_status);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong"); // [RQ2]

  property p_extra;
    @(posedge clk_in) disable iff (!rst_n)
    highside_switch_control[11] && !highside_recovery_pwm_setup[11] |=> highside_output_c_out;
  endproperty
  a_extra: assert property (p_extra) else $error("extra driver off"); // [RQ13]
endmodule

// ### verification/odrm_host_model.sv
// host controller model: issues one decoded frame command and collects the answer
`timescale 1ns/1ps
module odrm_host_model
  import odrm_pkg::*;
(
  // clock
  input wire logic clk_in,
  // command side
  output logic cmd_valid_out,
  output logic [1:0] cmd_op_out,
  output logic [5:0] cmd_addr_out,
  output logic [15:0] cmd_wdata_out,
  // answer side
  input wire logic rsp_valid_in,
  input wire logic [15:0] rsp_data_in
);
  initial
  begin
    cmd_valid_out = 1'b0;
    cmd_op_out = 2'h0;
    cmd_addr_out = 6'h00;
    cmd_wdata_out = 16'h0000;
  end

  // one frame: command taken at the next edge, answer sampled one edge later
  task automatic xfer(input logic [1:0] op, input logic [5:0] addr, input logic [15:0] wdata,
                      output logic [15:0] rdata, output logic got);
    logic [15:0] wd;
    wd = wdata;
    if (op == OP_WRITE && addr == ADDR_BRIDGE_SWITCH)
      wd = wdata & BRIDGE_SWITCH_BITS;
    if (op == OP_WRITE && addr == ADDR_HIGHSIDE_SWITCH)
      wd = wdata & HIGHSIDE_SWITCH_BITS;
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_op_out <= op;
    cmd_addr_out <= addr;
    cmd_wdata_out <= wd;
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    // scrambled fields once the command is gone
    cmd_addr_out <= ~addr;
    cmd_wdata_out <= ~wd;
    @(posedge clk_in);
    got = rsp_valid_in;
    rdata = rsp_data_in;
  endtask
endmodule

// ### verification/output_driver_register_map_tb_top.sv
// self-checking testbench of the output driver register map
`timescale 1ns/1ps
module output_driver_register_map_tb_top;
  import odrm_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic cmd_valid, rsp_valid, comm_err = 1'b0, chip_rst = 1'b1, tsd = 1'b0, tw = 1'b0;
  logic nr = 1'b0, pa = 1'b0, pb = 1'b0, active, a_lo, a_hi, b_lo, b_hi, hc, hd, he;
  logic [1:0] cmd_op;
  logic [5:0] cmd_addr, hs, ls;
  logic [15:0] cmd_wdata, rsp_data, oc_ev = 16'h0000, ol_ev = 16'h0000, sup_ev = 16'h0000;
  logic [7:0] gs;
  int error_cnt = 0;
  int samples_checked = 0;

  initial
  begin
    forever #12.5 clk_in = ~clk_in;
  end

  odrm_register_map #(.INFO_HEADER(16'h0c0d)) odrm_register_map_i (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op),
    .cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata), .rsp_valid_out(rsp_valid),
    .rsp_data_out(rsp_data), .global_status_out(gs), .overcurrent_event_in(oc_ev),
    .openload_event_in(ol_ev), .supply_event_in(sup_ev), .comm_error_in(comm_err),
    .chip_reset_in(chip_rst), .thermal_shutdown_in(tsd), .thermal_warning_in(tw),
    .not_ready_in(nr), .pulse_gate_input_a_in(pa), .pulse_gate_input_b_in(pb),
    .active_out(active), .half_bridge_hs_out(hs), .half_bridge_ls_out(ls),
    .config_highside_output_a_low_out(a_lo), .config_highside_output_a_high_out(a_hi),
    .config_highside_output_b_low_out(b_lo), .config_highside_output_b_high_out(b_hi),
    .highside_output_c_out(hc), .highside_output_d_out(hd), .highside_output_e_out(he));

  odrm_host_model odrm_host_model_i (
    .clk_in(clk_in), .cmd_valid_out(cmd_valid), .cmd_op_out(cmd_op),
    .cmd_addr_out(cmd_addr), .cmd_wdata_out(cmd_wdata), .rsp_valid_in(rsp_valid),
    .rsp_data_in(rsp_data));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one command; answer presence is always checked, data returned to caller
  task automatic cmd(input logic [1:0] op, input logic [5:0] a, input logic [15:0] wd,
                     output logic [15:0] rd);
    logic got;
    odrm_host_model_i.xfer(op, a, wd, rd, got);
    check("rsp_valid", 32'(got), 32'h1);
  endtask

  // let register and driver flops follow a change
  task automatic settle();
    repeat (2) @(posedge clk_in);
    #1;
  endtask

  task automatic t_bridge();
    logic [15:0] rd;
    cmd(OP_READ, ADDR_BRIDGE_SWITCH, 16'h0, rd);
    check("ctrl0 reset", 32'(rd), 32'h0);
    cmd(OP_WRITE, ADDR_BRIDGE_SWITCH, 16'h8101, rd);
    check("ctrl0 old", 32'(rd), 32'h0);
    cmd(OP_WRITE, ADDR_BRIDGE_SWITCH, 16'h6001, rd);
    check("ctrl0 old 2", 32'(rd), 32'h8101);
    settle();
    check("active", 32'(active), 32'h1);
    check("hs", 32'(hs), 32'h10);
    check("ls", 32'(ls), 32'h20);
    cmd(OP_WRITE, ADDR_BRIDGE_SWITCH, 16'hc041, rd);
    settle();
    check("both set hs", 32'(hs), 32'h00);
    check("both set ls", 32'(ls), 32'h02);
    cmd(OP_WRITE, ADDR_BRIDGE_SWITCH, 16'hfff0, rd);
    check("ctrl0 old 3", 32'(rd), 32'hc041);
    cmd(OP_READ, ADDR_BRIDGE_SWITCH, 16'h0, rd);
    check("standby clears", 32'(rd), 32'h0);
    settle();
    check("standby", 32'(active), 32'h0);
    check("standby hs", 32'({hs, ls}), 32'h0);
  endtask

  task automatic t_modes();
    logic [15:0] rd;
    logic [1:0] m;
    logic [2:0] ext;
    for (int i = 0; i < 4; i++)
    begin
      m = 2'(i);
      ext = 3'(i) ^ 3'h5;
      cmd(OP_WRITE, ADDR_HIGHSIDE_SWITCH, {m, ~m, ext, 9'h000}, rd);
      settle();
      check("mode a", 32'({a_lo, a_hi}), 32'({m == 2'h2, m == 2'h1}));
      check("mode b", 32'({b_lo, b_hi}), 32'({m == 2'h1, m == 2'h2}));
      check("extra hs", 32'({hc, hd, he}), 32'(ext));
    end
    cmd(OP_WRITE, ADDR_HIGHSIDE_SWITCH, 16'h0, rd);
  endtask

  task automatic t_pulse();
    logic [15:0] rd;
    cmd(OP_WRITE, ADDR_BRIDGE_RECOVERY, 16'h8000, rd);
    cmd(OP_WRITE, ADDR_HIGHSIDE_RECOVERY, 16'h0800, rd);
    cmd(OP_READ, ADDR_BRIDGE_RECOVERY, 16'h0, rd);
    check("ctrl2", 32'(rd), 32'h8000);
    cmd(OP_WRITE, ADDR_BRIDGE_SWITCH, 16'h8001, rd);
    cmd(OP_WRITE, ADDR_HIGHSIDE_SWITCH, 16'h0800, rd);
    settle();
    check("gated off a", 32'({hs[5], hc}), 32'h0);
    @(posedge clk_in);
    pa <= 1'b1;
    settle();
    check("gate a high", 32'({hs[5], hc}), 32'h2);
    @(posedge clk_in);
    pa <= 1'b0;
    pb <= 1'b1;
    settle();
    check("gate b high", 32'({hs[5], hc}), 32'h1);
    @(posedge clk_in);
    pb <= 1'b0;
    cmd(OP_WRITE, ADDR_BRIDGE_SWITCH, 16'h0, rd);
    cmd(OP_WRITE, ADDR_HIGHSIDE_SWITCH, 16'h0, rd);
  endtask

  task automatic t_status();
    logic [15:0] rd;
    logic [5:0] a;
    for (int i = 0; i < 3; i++)
    begin
      a = ADDR_OVERCURRENT + 6'(i);
      @(posedge clk_in);
      oc_ev <= (i == 0) ? 16'h8001 : 16'h0;
      ol_ev <= (i == 1) ? 16'h8001 : 16'h0;
      sup_ev <= (i == 2) ? 16'h8001 : 16'h0;
      @(posedge clk_in);
      {oc_ev, ol_ev, sup_ev} <= '0;
      cmd(OP_WRITE, a, 16'h0, rd);
      check("status write old", 32'(rd), 32'h8001);
      cmd(OP_READ, a, 16'h0, rd);
      check("status sticky", 32'(rd), 32'h8001);
      check("status summary", 32'(gs[2:1]), 32'((i == 0) ? 2'h2 : (i == 1) ? 2'h1 : 2'h3));
      cmd(OP_READ_CLEAR, a, 16'h0, rd);
      check("status rc", 32'(rd), 32'h8001);
      cmd(OP_READ, a, 16'h0, rd);
      check("status cleared", 32'(rd), 32'h0);
    end
  endtask

  task automatic t_info_mask();
    logic [15:0] rd;
    cmd(OP_READ_INFO, ADDR_FRAME_FORMAT, 16'h0, rd);
    check("frame id", 32'(rd), 32'h0200);
    cmd(OP_READ_INFO, ADDR_INFO_HEADER, 16'h0, rd);
    check("info header", 32'(rd), 32'h0c0d);
    cmd(OP_READ_INFO, 6'h05, 16'h0, rd);
    check("info unlisted", 32'(rd), 32'h0);
    cmd(OP_READ, 6'h20, 16'h0, rd);
    check("ram unlisted", 32'(rd), 32'h0);
    @(posedge clk_in);
    tw <= 1'b1;
    settle();
    check("warn shown", 32'(gs), 32'ha8);
    cmd(OP_WRITE, ADDR_MASK_CONFIG, 16'h0008, rd);
    cmd(OP_READ, ADDR_MASK_CONFIG, 16'h0, rd);
    check("mask reg", 32'(rd), 32'h0008);
    settle();
    check("warn masked", 32'(gs), 32'h20);
    @(posedge clk_in);
    tw <= 1'b0;
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    test_done();
  end

  initial
  begin
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_bridge();
    t_modes();
    t_pulse();
    t_status();
    t_info_mask();
    test_done();
  end
endmodule
